// ===== shared/svmon_pkg.sv
// Purpose: constants and types for the supply voltage event monitor
// Assumes: one 25 MHz core clock, plain register port
// Notes:   register indices are word indices on the register port
// Overview of operation
// RL1 - four-bit field picks one of sixteen levels
// RL2 - level 1111 selects the external trip input
// RL3 - qualified comparator crossing sets the event flag
// RL4 - direction bit one rising, zero falling
// RL5 - no event before reference settled after enable
// RL6 - settle interval fixed, crossings then ignored
// RL7 - software order: level, direction, enable, clear, irq
// RL8 - flag, enable, global enable at their bit positions
// RL9 - software disables before changing level or direction
// RL10 - works in sleep, wakes core, vectors if global
// RL11 - any reset returns registers, monitor disabled
// RL12 - control bit four switches the monitor on
// RL13 - control bit five reads reference settled
// RL14 - settle counter runs from enable, clears on disable
// RL15 - flag sticky until cleared, comparator synchronised
package svmon_pkg;
  localparam logic [2:0] SVMON_ADDR_CTRL    = 3'h0;
  localparam logic [2:0] SVMON_ADDR_INTCORE = 3'h1;
  localparam logic [2:0] SVMON_ADDR_PRIO2   = 3'h2;
  localparam logic [2:0] SVMON_ADDR_EN2     = 3'h3;
  localparam logic [2:0] SVMON_ADDR_FLAG2   = 3'h4;
  localparam logic [2:0] SVMON_ADDR_ISTAT   = 3'h5;
  localparam logic [2:0] SVMON_ADDR_ICLR    = 3'h6;
  localparam logic [2:0] SVMON_ADDR_IEN     = 3'h7;
  localparam int SVMON_BIT_DIR     = 7;
  localparam int SVMON_BIT_BGSTAB  = 6;
  localparam int SVMON_BIT_SETTLED = 5;
  localparam int SVMON_BIT_ENABLE  = 4;
  localparam int SVMON_BIT_GLOBAL  = 7;
  localparam int SVMON_BIT_EVT     = 2;
  localparam logic [3:0] SVMON_LEVEL_EXTERNAL = 4'hF;
  localparam logic [7:0] SVMON_CTRL_RESET  = 8'h05;
  localparam logic [7:0] SVMON_ZERO_RESET  = 8'h00;
  localparam logic [7:0] SVMON_PRIO_RESET  = 8'hFF;
  localparam int SVMON_CLK_HZ         = 25000000;
  localparam int SVMON_SETTLE_TIME_US = 25; // arbitrary settling time, microseconds
  localparam int SVMON_SETTLE_CYCLES  = (SVMON_SETTLE_TIME_US * (SVMON_CLK_HZ / 1000000));
  localparam int SVMON_IEV_EVENT   = 0;
  localparam int SVMON_IEV_SETTLED = 1;

  typedef struct packed {
    logic       dir;
    logic       enable;
    logic [3:0] level;
  } svmon_cfg_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } svmon_bus_type;
endpackage : svmon_pkg

// ===== verilog/svmon_settle.sv
// Purpose: reference settle timer for the voltage monitor
// Assumes: enable is a registered level
// Notes:   settled holds until enable drops
module svmon_settle
  import svmon_pkg::*;
#(
  parameter int CYCLES = SVMON_SETTLE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  output logic      settled
);
  logic [15:0] count;
  logic [15:0] en_cycles; // independent cycle count for the settle check

  // helper: cycles since enable, saturating, cleared on disable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_cycles <= 16'h0000;
    end else if (!enable) begin
      en_cycles <= 16'h0000;
    end else if (en_cycles != 16'hFFFF) begin
      en_cycles <= en_cycles + 16'h0001;
    end
  end

  // count from enable, restart on disable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count   <= 16'h0000;
      settled <= 1'b0;
    end else if (!enable) begin
      count   <= 16'h0000; // RL14
      settled <= 1'b0;
    end else if (count == 16'(CYCLES - 1)) begin
      settled <= 1'b1; // RL6
    end else begin
      count <= count + 16'h0001; // RL14
    end
  end

  property p_settle_time;
    @(posedge clk) disable iff (rst) settled == (en_cycles >= 16'(CYCLES));
  endproperty
  a_settle_time: assert property (p_settle_time) else $error("settle time wrong"); // RL14

  property p_settle_drop;
    @(posedge clk) disable iff (rst) !enable |=> !settled;
  endproperty
  a_settle_drop: assert property (p_settle_drop) else $error("settled without enable"); // RL14
endmodule // svmon_settle

// ===== verilog/svmon_top.sv
// Purpose: control, event and interrupt logic of the supply voltage monitor
// Assumes: comparator output is asynchronous and high when supply is above trip
// Notes:   read data appear the cycle after the read strobe
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
module svmon_top
  import svmon_pkg::*;
#(
  parameter int SETTLE_CYCLES = SVMON_SETTLE_CYCLES
) (
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       COMP_ABOVE,
  input  wire logic       BANDGAP_STABLE,
  input  wire logic       SLEEPING,
  output logic            REF_POWER_EN,
  output logic [3:0]      DIVIDER_TAP,
  output logic            USE_EXTERNAL_TRIP,
  output logic            WAKE,
  output logic            VECTOR_REQ,
  output logic            EVENT_PRIORITY,
  output logic            IRQ
);
  svmon_bus_type bus;
  svmon_cfg_type cfg;
  logic [7:0] intcore;
  logic [7:0] prio2;
  logic [7:0] en2;
  logic [7:0] flag2;
  logic [1:0] istat;
  logic [1:0] ien;
  logic       comp_meta;
  logic       comp_sync;
  logic       comp_prev;
  logic       bg_meta;
  logic       bg_sync;
  logic       settled;
  logic       settled_prev;
  logic       crossing;
  logic       event_hit;
  logic [1:0] next_istat;

  typedef enum logic [2:0] {
    SVMON_OFF     = 3'b001,
    SVMON_SETTLE  = 3'b010,
    SVMON_ARMED   = 3'b100
  } svmon_state_type;
  svmon_state_type state;

  function automatic logic is_addr(input svmon_bus_type b, input logic [2:0] a);
    return b.addr == a;
  endfunction

  assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

  // control register fields: level, enable, direction
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cfg <= '{dir: SVMON_CTRL_RESET[SVMON_BIT_DIR], enable: SVMON_CTRL_RESET[SVMON_BIT_ENABLE],
               level: SVMON_CTRL_RESET[3:0]}; // RL11
    end else if (bus.wr && is_addr(bus, SVMON_ADDR_CTRL)) begin
      cfg.level  <= bus.wdata[3:0]; // RL1
      cfg.enable <= bus.wdata[SVMON_BIT_ENABLE]; // RL12
      cfg.dir    <= bus.wdata[SVMON_BIT_DIR]; // RL4
    end
  end

  // interrupt core, priority and enable registers
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      intcore <= SVMON_ZERO_RESET; // RL11
      prio2   <= SVMON_PRIO_RESET;
      en2     <= SVMON_ZERO_RESET;
      ien     <= 2'b00;
    end else if (bus.wr) begin
      if (is_addr(bus, SVMON_ADDR_INTCORE)) intcore <= bus.wdata;
      if (is_addr(bus, SVMON_ADDR_PRIO2)) prio2 <= bus.wdata;
      if (is_addr(bus, SVMON_ADDR_EN2)) en2 <= bus.wdata;
      if (is_addr(bus, SVMON_ADDR_IEN)) ien <= bus.wdata[1:0];
    end
  end

  // synchronisers for comparator and bandgap status
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
      comp_prev <= 1'b0;
      bg_meta   <= 1'b0;
      bg_sync   <= 1'b0;
    end else begin
      comp_meta <= COMP_ABOVE; // RL15
      comp_sync <= comp_meta;
      comp_prev <= comp_sync;
      bg_meta   <= BANDGAP_STABLE;
      bg_sync   <= bg_meta;
    end
  end

  svmon_settle #(
    .CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .clk     (CORE_CLK),
    .rst     (RST),
    .enable  (cfg.enable),
    .settled (settled)
  );

  // sequencer: off, settling, armed
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= SVMON_OFF;
    end else begin
      case (state)
        SVMON_OFF:    if (cfg.enable) state <= SVMON_SETTLE;
        SVMON_SETTLE: if (!cfg.enable) state <= SVMON_OFF;
                      else if (settled) state <= SVMON_ARMED; // RL5
        SVMON_ARMED:  if (!cfg.enable) state <= SVMON_OFF;
        default:      state <= SVMON_OFF;
      endcase
    end
  end

  // crossing in configured direction, also level condition at arming
  assign crossing  = cfg.dir ? (comp_sync && !comp_prev) : (!comp_sync && comp_prev); // RL4
  assign event_hit = (state == SVMON_ARMED) && settled &&
                     (crossing || ((cfg.dir == comp_sync) && !settled_prev)); // RL3 RL5

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) settled_prev <= 1'b0;
    else settled_prev <= (state == SVMON_ARMED);
  end

  // peripheral flag register: set wins over software clear
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      flag2 <= SVMON_ZERO_RESET;
    end else begin
      if (bus.wr && is_addr(bus, SVMON_ADDR_FLAG2)) flag2 <= bus.wdata; // RL15
      if (event_hit) flag2[SVMON_BIT_EVT] <= 1'b1; // RL3 RL8
    end
  end

  // sticky status of the block's own events, write-one-to-clear
  always_comb begin
    next_istat = istat;
    if (bus.wr && is_addr(bus, SVMON_ADDR_ICLR)) next_istat = istat & ~bus.wdata[1:0];
    if (event_hit) next_istat[SVMON_IEV_EVENT] = 1'b1;
    if (settled && !settled_prev && state == SVMON_SETTLE)
      next_istat[SVMON_IEV_SETTLED] = 1'b1;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) istat <= 2'b00;
    else istat <= next_istat;
  end

  // read data, one cycle after the strobe
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        SVMON_ADDR_CTRL:    RDATA <= {cfg.dir, bg_sync, settled, cfg.enable, cfg.level}; // RL13
        SVMON_ADDR_INTCORE: RDATA <= intcore;
        SVMON_ADDR_PRIO2:   RDATA <= prio2;
        SVMON_ADDR_EN2:     RDATA <= en2;
        SVMON_ADDR_FLAG2:   RDATA <= flag2;
        SVMON_ADDR_ISTAT:   RDATA <= {6'h00, istat};
        SVMON_ADDR_IEN:     RDATA <= {6'h00, ien};
        default:            RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // analog controls and core wake / vector requests
  assign REF_POWER_EN      = cfg.enable;
  assign DIVIDER_TAP       = cfg.level; // RL1
  assign USE_EXTERNAL_TRIP = cfg.enable && (cfg.level == SVMON_LEVEL_EXTERNAL); // RL2
  assign WAKE = SLEEPING && flag2[SVMON_BIT_EVT] && en2[SVMON_BIT_EVT]; // RL10
  assign VECTOR_REQ = flag2[SVMON_BIT_EVT] && en2[SVMON_BIT_EVT] &&
                      intcore[SVMON_BIT_GLOBAL]; // RL8 RL10
  assign EVENT_PRIORITY = prio2[SVMON_BIT_EVT];
  assign IRQ = |(istat & ien);

  sequence s_settling;
    state == SVMON_SETTLE;
  endsequence

  property p_no_early_event;
    @(posedge CORE_CLK) disable iff (RST)
      (!settled && !flag2[SVMON_BIT_EVT] && !(bus.wr && is_addr(bus, SVMON_ADDR_FLAG2)))
        |=> !flag2[SVMON_BIT_EVT];
  endproperty
  a_no_early_event: assert property (p_no_early_event) else $error("event before settle"); // RL5

  property p_event_sets_flag;
    @(posedge CORE_CLK) disable iff (RST) event_hit |=> flag2[SVMON_BIT_EVT];
  endproperty
  a_event_sets_flag: assert property (p_event_sets_flag) else $error("flag not set"); // RL3

  property p_rise_dir;
    @(posedge CORE_CLK) disable iff (RST)
      (state == SVMON_ARMED && settled_prev && cfg.dir && $fell(comp_sync)) |-> !event_hit;
  endproperty
  a_rise_dir: assert property (p_rise_dir) else $error("falling edge in rising mode"); // RL4

  property p_sticky;
    @(posedge CORE_CLK) disable iff (RST)
      (flag2[SVMON_BIT_EVT] && !(bus.wr && is_addr(bus, SVMON_ADDR_FLAG2)))
        |=> flag2[SVMON_BIT_EVT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost"); // RL15

  property p_ext_sel;
    @(posedge CORE_CLK) disable iff (RST)
      (cfg.enable && cfg.level == SVMON_LEVEL_EXTERNAL) |-> USE_EXTERNAL_TRIP;
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("external input not used"); // RL2

  property p_wake;
    @(posedge CORE_CLK) disable iff (RST)
      (SLEEPING && event_hit && en2[SVMON_BIT_EVT]) ##1 (SLEEPING && en2[SVMON_BIT_EVT])
        |-> WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake"); // RL10

  property p_vector;
    @(posedge CORE_CLK) disable iff (RST) VECTOR_REQ |-> intcore[SVMON_BIT_GLOBAL];
  endproperty
  a_vector: assert property (p_vector) else $error("vector without global enable"); // RL8

  property p_enable_bit;
    @(posedge CORE_CLK) disable iff (RST)
      (bus.wr && is_addr(bus, SVMON_ADDR_CTRL)) |=> cfg.enable == $past(bus.wdata[4]);
  endproperty
  a_enable_bit: assert property (p_enable_bit) else $error("enable bit wrong"); // RL12

  property p_settle_seq;
    @(posedge CORE_CLK) disable iff (RST)
      s_settling ##0 (!flag2[SVMON_BIT_EVT] && !(bus.wr && is_addr(bus, SVMON_ADDR_FLAG2)))
        |=> !flag2[SVMON_BIT_EVT];
  endproperty
  a_settle_seq: assert property (p_settle_seq) else $error("event while settling"); // RL6

  // edges of the synchronised comparator
  sequence s_comp_rise;
    !comp_sync ##1 comp_sync;
  endsequence

  sequence s_comp_fall;
    comp_sync ##1 !comp_sync;
  endsequence

  property p_rise_event;
    @(posedge CORE_CLK) disable iff (RST)
      s_comp_rise ##0 (state == SVMON_ARMED && cfg.dir) |=> flag2[SVMON_BIT_EVT];
  endproperty
  a_rise_event: assert property (p_rise_event) else $error("rise missed"); // RL3 RL4

  property p_fall_event;
    @(posedge CORE_CLK) disable iff (RST)
      s_comp_fall ##0 (state == SVMON_ARMED && !cfg.dir) |=> flag2[SVMON_BIT_EVT];
  endproperty
  a_fall_event: assert property (p_fall_event) else $error("fall missed"); // RL3 RL4

  property p_arm_level;
    @(posedge CORE_CLK) disable iff (RST)
      s_settling ##1 (state == SVMON_ARMED && cfg.dir == comp_sync) |=> flag2[SVMON_BIT_EVT];
  endproperty
  a_arm_level: assert property (p_arm_level) else $error("arming level missed"); // RL3

  property p_level_tap;
    @(posedge CORE_CLK) disable iff (RST)
      (bus.wr && is_addr(bus, SVMON_ADDR_CTRL)) |=> DIVIDER_TAP == $past(bus.wdata[3:0]);
  endproperty
  a_level_tap: assert property (p_level_tap) else $error("level not applied"); // RL1

  property p_dir_bit;
    @(posedge CORE_CLK) disable iff (RST)
      (bus.wr && is_addr(bus, SVMON_ADDR_CTRL)) |=> cfg.dir == $past(bus.wdata[SVMON_BIT_DIR]);
  endproperty
  a_dir_bit: assert property (p_dir_bit) else $error("direction not applied"); // RL4

  property p_ext_off;
    @(posedge CORE_CLK) disable iff (RST)
      !(cfg.enable && cfg.level == SVMON_LEVEL_EXTERNAL) |-> !USE_EXTERNAL_TRIP;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("external input wrongly used"); // RL2

  property p_reset_off;
    @(posedge CORE_CLK)
      RST |-> !REF_POWER_EN && state == SVMON_OFF && flag2 == SVMON_ZERO_RESET;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("reset state wrong"); // RL11

  property p_state_off;
    @(posedge CORE_CLK) disable iff (RST) !cfg.enable |=> state == SVMON_OFF;
  endproperty
  a_state_off: assert property (p_state_off) else $error("sequencer on while off"); // RL12

  property p_flag_write;
    @(posedge CORE_CLK) disable iff (RST)
      (bus.wr && is_addr(bus, SVMON_ADDR_FLAG2) && !event_hit) |=> flag2 == $past(bus.wdata);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag write lost"); // RL8

  property p_settled_read;
    @(posedge CORE_CLK) disable iff (RST)
      (bus.rd && is_addr(bus, SVMON_ADDR_CTRL)) |=> RDATA[SVMON_BIT_SETTLED] == $past(settled);
  endproperty
  a_settled_read: assert property (p_settled_read) else $error("settled bit wrong"); // RL13

  property p_comp_sync;
    @(posedge CORE_CLK) disable iff (RST)
      !$past(RST, 2) |-> comp_sync == $past(COMP_ABOVE, 2);
  endproperty
  a_comp_sync: assert property (p_comp_sync) else $error("comparator sync wrong"); // RL15

  property p_bg_sync;
    @(posedge CORE_CLK) disable iff (RST)
      !$past(RST, 2) |-> bg_sync == $past(BANDGAP_STABLE, 2);
  endproperty
  a_bg_sync: assert property (p_bg_sync) else $error("bandgap sync wrong"); // RL13
endmodule // svmon_top

// ===== sim/svmon_analog_model.sv
// Purpose: comparator and reference model on the far side of the monitor
// Assumes: supply and external trip are 8-bit codes set by the bench
// Notes:   comparator output toggles while the reference is powered down
module svmon_analog_model (
  input  wire logic       clk,
  input  wire logic       ref_power_en,
  input  wire logic [3:0] divider_tap,
  input  wire logic       use_external_trip,
  input  wire logic [7:0] supply,
  input  wire logic [7:0] external_trip_input,
  output logic            comp_above,
  output logic            bandgap_stable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] trip;
  logic       junk = 1'b0;
  // trip point from the divider tap or the external pin
  assign trip = use_external_trip ? external_trip_input : {divider_tap, 4'h8};
  // a powered-down comparator gives no stable level
  always_ff @(posedge clk) begin
    junk <= ~junk;
  end
  // comparator and reference only meaningful while powered
  assign comp_above     = ref_power_en ? (supply >= trip) : junk;
  assign bandgap_stable = ref_power_en;
endmodule // svmon_analog_model

// ===== sim/tb_svmon.sv
// Purpose: self-checking bench for the voltage monitor register and event logic
// Assumes: settle count shortened to 8 cycles
// Notes:   register tasks follow the one-cycle strobe port
module tb_svmon
  import svmon_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 8;
  logic       CORE_CLK = 1'b0;
  logic       RST, WR, RD, SLEEPING;
  logic [2:0] ADDR;
  logic [7:0] WDATA, RDATA, supply, ext_trip;
  logic       COMP_ABOVE, BANDGAP_STABLE, REF_POWER_EN, USE_EXTERNAL_TRIP;
  logic       WAKE, VECTOR_REQ, EVENT_PRIORITY, IRQ;
  logic [3:0] DIVIDER_TAP;
  int         n_mismatch = 0;
  int         compares = 0;
  // clock
  always #20 CORE_CLK = ~CORE_CLK;
  svmon_top #(.SETTLE_CYCLES(SETTLE)) uut (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .COMP_ABOVE(COMP_ABOVE),
    .BANDGAP_STABLE(BANDGAP_STABLE), .SLEEPING(SLEEPING), .REF_POWER_EN(REF_POWER_EN),
    .DIVIDER_TAP(DIVIDER_TAP), .USE_EXTERNAL_TRIP(USE_EXTERNAL_TRIP), .WAKE(WAKE),
    .VECTOR_REQ(VECTOR_REQ), .EVENT_PRIORITY(EVENT_PRIORITY), .IRQ(IRQ));
  svmon_analog_model u_analog (.clk(CORE_CLK), .ref_power_en(REF_POWER_EN),
    .divider_tap(DIVIDER_TAP), .use_external_trip(USE_EXTERNAL_TRIP), .supply(supply),
    .external_trip_input(ext_trip), .comp_above(COMP_ABOVE),
    .bandgap_stable(BANDGAP_STABLE));
  // verdict and end of run
  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // compare and report
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // register write, returns once the write has landed
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= d;
    @(posedge CORE_CLK);
    WR    <= 1'b0;
    #1;
  endtask
  // register read, data taken in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge CORE_CLK);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge CORE_CLK);
    RD   <= 1'b0;
    #1;
    d = RDATA;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask
  // bounded wait for one register bit
  task automatic poll(input logic [2:0] a, input int b, input logic v);
    logic [7:0] d;
    for (int i = 0; i < 60; i++) begin
      rd(a, d);
      if (d[b] === v) return;
    end
    check({7'h0, d[b]}, {7'h0, v});
    finish_test();
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    check(8'h00, 8'h01);
    finish_test();
  end
  // main sequence
  initial begin
    RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 3'h0;
    WDATA = 8'h00;
    SLEEPING = 1'b0;
    supply = 8'h60;
    ext_trip = 8'hA0;
    repeat (8) @(posedge CORE_CLK);
    RST <= 1'b0;
    rdc(SVMON_ADDR_CTRL, SVMON_CTRL_RESET);
    rdc(SVMON_ADDR_PRIO2, SVMON_PRIO_RESET);
    rdc(SVMON_ADDR_FLAG2, SVMON_ZERO_RESET);
    check({3'h0, EVENT_PRIORITY, DIVIDER_TAP}, 8'h15);
    // every level, read-only bits written high
    for (int i = 0; i < 16; i++) begin
      wr(SVMON_ADDR_CTRL, 8'hE0 | i[7:0]);
      rdc(SVMON_ADDR_CTRL, 8'h80 | i[7:0]);
      check({3'h0, USE_EXTERNAL_TRIP, DIVIDER_TAP}, {4'h0, i[3:0]});
    end
    wr(SVMON_ADDR_INTCORE, 8'hA5);
    rdc(SVMON_ADDR_INTCORE, 8'hA5);
    wr(SVMON_ADDR_PRIO2, 8'h00);
    rdc(SVMON_ADDR_PRIO2, 8'h00);
    check({7'h0, EVENT_PRIORITY}, 8'h00);
    wr(SVMON_ADDR_ISTAT, 8'hFF);
    rdc(SVMON_ADDR_ISTAT, 8'h00);
    rdc(SVMON_ADDR_ICLR, 8'h00);
    wr(SVMON_ADDR_INTCORE, 8'h00);
    // falling detect, dip during settling is ignored
    wr(SVMON_ADDR_CTRL, 8'h03);
    wr(SVMON_ADDR_CTRL, 8'h13);
    check({7'h0, REF_POWER_EN}, 8'h01);
    supply <= 8'h10;
    repeat (3) @(posedge CORE_CLK);
    supply <= 8'h60;
    poll(SVMON_ADDR_CTRL, SVMON_BIT_SETTLED, 1'b1);
    rdc(SVMON_ADDR_CTRL, 8'h73);
    wr(SVMON_ADDR_FLAG2, 8'h00);
    rdc(SVMON_ADDR_FLAG2, 8'h00);
    wr(SVMON_ADDR_IEN, 8'h01);
    supply <= 8'h10;
    poll(SVMON_ADDR_FLAG2, SVMON_BIT_EVT, 1'b1);
    rdc(SVMON_ADDR_ISTAT, 8'h03);
    check({7'h0, IRQ}, 8'h01);
    wr(SVMON_ADDR_IEN, 8'h00);
    check({7'h0, IRQ}, 8'h00);
    wr(SVMON_ADDR_IEN, 8'h01);
    check({7'h0, IRQ}, 8'h01);
    supply <= 8'h60;
    // wake and vector with the flag set
    SLEEPING <= 1'b1;
    wr(SVMON_ADDR_EN2, 8'h04);
    check({6'h0, WAKE, VECTOR_REQ}, 8'h02);
    wr(SVMON_ADDR_INTCORE, 8'h80);
    check({6'h0, WAKE, VECTOR_REQ}, 8'h03);
    wr(SVMON_ADDR_FLAG2, 8'h00);
    check({6'h0, WAKE, VECTOR_REQ}, 8'h00);
    rdc(SVMON_ADDR_FLAG2, 8'h00);
    wr(SVMON_ADDR_ICLR, 8'h03);
    check({7'h0, IRQ}, 8'h00);
    rdc(SVMON_ADDR_ISTAT, 8'h00);
    // rising detect on the external input
    wr(SVMON_ADDR_CTRL, 8'h0F);
    repeat (4) @(posedge CORE_CLK);
    rdc(SVMON_ADDR_CTRL, 8'h0F);
    supply <= 8'h10;
    wr(SVMON_ADDR_CTRL, 8'h8F);
    wr(SVMON_ADDR_CTRL, 8'h9F);
    check({7'h0, USE_EXTERNAL_TRIP}, 8'h01);
    poll(SVMON_ADDR_CTRL, SVMON_BIT_SETTLED, 1'b1);
    wr(SVMON_ADDR_FLAG2, 8'h00);
    rdc(SVMON_ADDR_FLAG2, 8'h00);
    supply <= 8'hC0;
    poll(SVMON_ADDR_FLAG2, SVMON_BIT_EVT, 1'b1);
    // reset in mid-run
    @(posedge CORE_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    rdc(SVMON_ADDR_CTRL, SVMON_CTRL_RESET);
    rdc(SVMON_ADDR_FLAG2, 8'h00);
    rdc(SVMON_ADDR_INTCORE, 8'h00);
    check({6'h0, REF_POWER_EN, IRQ}, 8'h00);
    finish_test();
  end
endmodule // tb_svmon
